/* pcc_defs.vh */
// constants for the port and common control message framer
`ifndef PCC_DEFS_VH
`define PCC_DEFS_VH
`define PCC_MT_PORT 7'h10
`define PCC_MT_PORT_ACK 7'h11
`define PCC_MT_COMMON 7'h12
`define PCC_MT_COMMON_ACK 7'h13
`define PCC_IE_CFE 8'h20
`define PCC_IE_CFID 8'h21
`define PCC_IE_VARIANT 8'h22
`define PCC_IE_IFID 8'h23
`define PCC_IE_PG_HI 4'hE
`define PCC_IE_RC_HI 4'hF
`define PCC_HDR_LEN 5'h04
`define PCC_MAX_LEN 5'h10
`define PCC_FE206 8'hCE
`define PCC_PD_DEFAULT 8'h48
`define PCC_CFID_VAR_MASK 8'h01
`define PCC_CFID_RC_MASK 8'h02
`define PCC_CFID_IF_MASK 8'h04
`endif

/* pcc_msg_ram.v */
// small message buffer with registered read data
`timescale 1ns/10ps
`default_nettype none
module pcc_msg_ram (
  input wire mclk,
  input wire wrEn,
  input wire [3:0] wrAddr,
  input wire [7:0] wrData,
  input wire [3:0] rdAddr,
  output reg [7:0] rdData
);
  reg [7:0] mem [0:15];
  always @(posedge mclk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule
`default_nettype wire

/* pcc_framer.v */
// port and common control message framer: serial transmit and receive with auto acknowledge
`timescale 1ns/10ps
`default_nettype none
`include "pcc_defs.vh"
module pcc_framer (
  input wire mclk,
  input wire rst_n,
  input wire isAccessSide,
  input wire [7:0] protoDisc,
  input wire txReq,
  input wire txCommon,
  input wire [15:0] txAddr,
  input wire [23:0] txFunc,
  input wire [7:0] txGrade,
  input wire [23:0] txVariant,
  input wire [7:0] txRejCause,
  input wire [39:0] txIfId,
  input wire rxBit,
  input wire rxFrame,
  output reg txBit,
  output reg txFrame,
  output reg txBusy,
  output reg rxValid,
  output reg rxError,
  output reg [6:0] rxType,
  output reg [15:0] rxAddr,
  output reg [23:0] rxFunc
);
  // ----------------------------------------
  // reset and input synchronisers
  // ----------------------------------------
  reg rstSync1, rstN;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1 <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstN <= rstSync1;
    end
  end
  reg bitMeta_q, bitS_q, frmMeta_q;
  reg [1:0] frmS_q;
  wire sBit = bitS_q;
  wire sFrm = frmS_q[0];
  always @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      bitMeta_q <= 1'b0;
      bitS_q <= 1'b0;
      frmMeta_q <= 1'b0;
      frmS_q <= 2'h0;
    end else begin
      bitMeta_q <= rxBit;
      bitS_q <= bitMeta_q;
      frmMeta_q <= rxFrame;
      frmS_q <= {frmS_q[0], frmMeta_q};
    end
  end
  wire frmEnd = frmS_q[1] & ~frmS_q[0];
  // ----------------------------------------
  // receive: octet assembly, lsb first
  // ----------------------------------------
  reg [7:0] rxSh_q;
  reg [2:0] rxBitCnt_q;
  reg [4:0] rxLen_q;
  reg [7:0] rxOct [0:15];
  reg [6:0] seenMask_q;
  reg rxBad_q;
  wire [7:0] rxByte = {sBit, rxSh_q[7:1]};
  genvar gi;
  always @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      rxSh_q <= 8'h00;
      rxBitCnt_q <= 3'h0;
      rxLen_q <= 5'h00;
    end else if (sFrm) begin
      rxSh_q <= rxByte;
      rxBitCnt_q <= rxBitCnt_q + 3'h1;
      if (rxBitCnt_q == 3'h7 && rxLen_q != `PCC_MAX_LEN) begin
        rxLen_q <= rxLen_q + 5'h01;
      end
    end else if (frmEnd) begin
      rxBitCnt_q <= 3'h0;
      rxLen_q <= 5'h00;
    end
  end
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : gOct
      always @(posedge mclk) begin
        if (sFrm && rxBitCnt_q == 3'h7 && rxLen_q == gi) begin
          rxOct[gi] <= rxByte;
        end
      end
    end
  endgenerate
  // ----------------------------------------
  // receive: message check on frame end
  // ----------------------------------------
  wire [6:0] mt = rxOct[3][6:0];
  wire isPort = (mt == `PCC_MT_PORT);
  wire isPortAck = (mt == `PCC_MT_PORT_ACK);
  wire isCom = (mt == `PCC_MT_COMMON);
  wire isComAck = (mt == `PCC_MT_COMMON_ACK);
  wire [7:0] fi = rxOct[4];
  wire portFe206 = (rxOct[6] == `PCC_FE206);
  wire [7:0] cf = rxOct[6];
  // expected common control length from function id
  wire [4:0] comLen = 5'd7 + (cf[0] ? 5'd3 : 5'd0) + (cf[1] ? 5'd1 : 5'd0) + (cf[2] ? 5'd5 : 5'd0);
  reg lenOk;
  always @* begin
    lenOk = 1'b0;
    if (isPort) begin
      // grading only from access side, required with FE206
      lenOk = isAccessSide ? (rxLen_q == 5'd7) :
              (portFe206 ? (rxLen_q == 5'd8 && rxOct[7][7:4] == `PCC_IE_PG_HI) : (rxLen_q == 5'd7));
    end else if (isPortAck || isComAck) begin
      lenOk = (rxLen_q == 5'd7);
    end else if (isCom) begin
      lenOk = (rxLen_q == comLen);
    end
  end
  wire idOk = (isPort || isPortAck) ? (fi == `PCC_IE_CFE) : (fi == `PCC_IE_CFID);
  wire rxGood = lenOk & idOk & (rxOct[0] == protoDisc);
  reg ackPend_q;
  wire ackStart;
  reg ackCom_q;
  reg [15:0] ackAddr_q;
  reg [23:0] ackFunc_q;
  always @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      rxValid <= 1'b0;
      rxError <= 1'b0;
      rxType <= 7'h00;
      rxAddr <= 16'h0000;
      rxFunc <= 24'h00_0000;
      ackPend_q <= 1'b0;
      ackCom_q <= 1'b0;
      ackAddr_q <= 16'h0000;
      ackFunc_q <= 24'h00_0000;
    end else begin
      rxValid <= frmEnd & rxGood;
      rxError <= frmEnd & ~rxGood;
      if (frmEnd && rxGood) begin
        rxType <= mt;
        rxAddr <= {rxOct[1], rxOct[2]};
        rxFunc <= {rxOct[4], rxOct[5], rxOct[6]};
      end
      if (frmEnd && rxGood && (isPort || isCom)) begin
        ackPend_q <= 1'b1;
        ackCom_q <= isCom;
        ackAddr_q <= {rxOct[1], rxOct[2]};
        ackFunc_q <= {rxOct[4], rxOct[5], rxOct[6]};
      end else if (ackStart) begin
        ackPend_q <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // transmit: message build into buffer
  // ----------------------------------------
  localparam ST_IDLE = 4'b0001;
  localparam ST_LOAD = 4'b0010;
  localparam ST_SEND = 4'b0100;
  localparam ST_GAP = 4'b1000;
  reg [3:0] state_q;
  reg [4:0] txLen_q, txIdx_q, ldIdx_q;
  reg [2:0] txBitCnt_q;
  reg [127:0] img_q;
  wire idle = (state_q == ST_IDLE);
  assign ackStart = idle & ackPend_q; // acks go before new requests
  wire [7:0] ramRd;
  pcc_msg_ram uRam (
    .mclk(mclk),
    .wrEn(state_q == ST_LOAD),
    .wrAddr(ldIdx_q[3:0]),
    .wrData(img_q[127:120]),
    .rdAddr(txIdx_q[3:0]),
    .rdData(ramRd)
  );
  reg [127:0] newImg;
  reg [4:0] newLen;
  always @* begin
    newImg = 128'h0;
    newLen = 5'd7;
    if (ackStart) begin
      newImg[127:72] = {protoDisc, ackAddr_q, 1'b0, ackCom_q ? `PCC_MT_COMMON_ACK : `PCC_MT_PORT_ACK,
                        ackFunc_q};
    end else if (!txCommon) begin
      newImg[127:72] = {protoDisc, txAddr, 1'b0, `PCC_MT_PORT, `PCC_IE_CFE, txFunc[15:0]};
      if (isAccessSide && txFunc[7:0] == `PCC_FE206) begin
        newImg[71:64] = {`PCC_IE_PG_HI, txGrade[3:0]};
        newLen = 5'd8;
      end
    end else begin
      newImg[127:72] = {protoDisc, txAddr, 1'b0, `PCC_MT_COMMON, `PCC_IE_CFID, txFunc[15:0]};
      if (txFunc[0]) begin
        newImg = newImg | ({`PCC_IE_VARIANT, 8'h01, txVariant[7:0], 104'h0} >> {newLen, 3'b000});
        newLen = newLen + 5'd3;
      end
      if (txFunc[1]) begin
        newImg = newImg | ({`PCC_IE_RC_HI, txRejCause[3:0], 120'h0} >> {newLen, 3'b000});
        newLen = newLen + 5'd1;
      end
      if (txFunc[2]) begin
        newImg = newImg | ({`PCC_IE_IFID, 8'h03, txIfId[23:0], 88'h0} >> {newLen, 3'b000});
        newLen = newLen + 5'd5;
      end
    end
  end
  // ----------------------------------------
  // transmit: serialiser
  // ----------------------------------------
  always @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      state_q <= ST_IDLE;
      txLen_q <= 5'h00;
      txIdx_q <= 5'h00;
      ldIdx_q <= 5'h00;
      txBitCnt_q <= 3'h0;
      img_q <= 128'h0;
      txBit <= 1'b0;
      txFrame <= 1'b0;
      txBusy <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          txFrame <= 1'b0;
          if (ackStart || txReq) begin
            img_q <= newImg;
            txLen_q <= newLen;
            ldIdx_q <= 5'h00;
            txIdx_q <= 5'h00;
            txBusy <= 1'b1;
            state_q <= ST_LOAD;
          end else begin
            txBusy <= 1'b0;
          end
        end
        ST_LOAD: begin
          img_q <= {img_q[119:0], 8'h00};
          ldIdx_q <= ldIdx_q + 5'h01;
          if (ldIdx_q == txLen_q - 5'h01) begin
            state_q <= ST_GAP;
          end
        end
        ST_GAP: begin
          txBitCnt_q <= 3'h0;
          state_q <= ST_SEND;
        end
        ST_SEND: begin
          txFrame <= 1'b1;
          txBit <= ramRd[txBitCnt_q];
          txBitCnt_q <= txBitCnt_q + 3'h1;
          if (txBitCnt_q == 3'h6) begin
            txIdx_q <= txIdx_q + 5'h01;
          end
          if (txBitCnt_q == 3'h7 && txIdx_q == txLen_q) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* pcc_framer_asserts.sv */
// port checks for the control message framer
`timescale 1ns/10ps
`default_nettype none
module pcc_framer_asserts (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic txReq,
  input wire logic txFrame,
  input wire logic txBusy,
  input wire logic rxValid,
  input wire logic rxError,
  input wire logic [6:0] rxType
);
  logic [7:0] bitCnt_q;
  logic ackDue_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ----
  // cycles of the current frame
  // ----
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bitCnt_q <= 8'h00;
    end else begin
      bitCnt_q <= txFrame ? bitCnt_q + 8'h01 : 8'h00;
    end
  end
  // an accepted port or common control may chain an ack right after a frame
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ackDue_q <= 1'b0;
    end else if (rxValid && !rxType[0]) begin
      ackDue_q <= 1'b1;
    end else if (!txFrame && bitCnt_q != 8'h00) begin
      ackDue_q <= 1'b0;
    end
  end
  octet_count_a: assert property ($fell(txFrame) |-> bitCnt_q[2:0] == 3'h0 && bitCnt_q >= 8'h38 && bitCnt_q <= 8'h80)
    else $error("frame not whole octets of legal length");
  frame_busy_a: assert property (txFrame |-> txBusy)
    else $error("frame outside busy");
  build_gap_a: assert property ($rose(txBusy) |-> !txFrame [*8])
    else $error("frame started too early");
  frame_end_a: assert property ($fell(txFrame) && !ackDue_q && !$past(txReq) |-> ##[0:1] !txBusy)
    else $error("busy stuck after frame");
  flag_excl_a: assert property (!(rxValid && rxError))
    else $error("valid and error together");
  valid_pulse_a: assert property (rxValid |=> !rxValid)
    else $error("valid longer than one cycle");
  error_pulse_a: assert property (rxError |=> !rxError)
    else $error("error longer than one cycle");
  type_code_a: assert property (rxValid |=> rxType >= 7'h10 && rxType <= 7'h13)
    else $error("reserved message type accepted");
  auto_ack_a: assert property (rxValid ##1 !rxType[0] |-> ##[0:300] txBusy)
    else $error("no acknowledgement sent");
endmodule
bind pcc_framer pcc_framer_asserts pcc_framer_asserts_inst (.mclk(mclk), .rst_n(rst_n), .txReq(txReq), .txFrame(txFrame),
  .txBusy(txBusy), .rxValid(rxValid), .rxError(rxError), .rxType(rxType));
`default_nettype wire

/* pcc_peer_model.sv */
// far-end control protocol peer: serial receiver and sender
`timescale 1ns/10ps
`default_nettype none
module pcc_peer_model (
  input wire logic mclk,
  input wire logic txBit,
  input wire logic txFrame,
  output logic rxBit,
  output logic rxFrame,
  output logic [127:0] got,
  output logic [15:0] gotLen,
  output logic [15:0] nMsg
);
  logic [7:0] nBits = 8'h00;
  initial begin
    rxBit = 1'b0;
    rxFrame = 1'b0;
    gotLen = 16'h0000;
    nMsg = 16'h0000;
  end
  // ----
  // capture octets, bit 0 first
  // ----
  always @(posedge mclk) begin
    if (txFrame) begin
      got[nBits[6:0]] <= txBit;
      nBits <= nBits + 8'h01;
    end else if (nBits != 8'h00) begin
      gotLen <= {11'h000, nBits[7:3]};
      nMsg <= nMsg + 16'h0001;
      nBits <= 8'h00;
    end
  end
  // octet 0 sits in msg[7:0]; line toggles once the frame is over
  task automatic send(input logic [127:0] msg, input int n);
    for (int i = 0; i < 8 * n; i++) begin
      @(posedge mclk);
      rxFrame <= 1'b1;
      rxBit <= msg[i];
    end
    @(posedge mclk);
    rxFrame <= 1'b0;
    rxBit <= ~rxBit;
  endtask
endmodule
`default_nettype wire

/* port_and_common_control_messages_tb.sv */
// testbench for the control message framer
`timescale 1ns/10ps
`default_nettype none
module port_and_common_control_messages_tb;
  logic mclk, rst_n, isAccessSide, txReq, txCommon, txBit, txFrame, txBusy, rxValid, rxError, rxBit, rxFrame;
  logic [15:0] txAddr, rxAddr, msgs, gotLen, nMsg;
  logic [23:0] txFunc, rxFunc;
  logic [6:0] rxType;
  logic [127:0] got;
  integer nErrors = 0, totalChecks = 0, cycles = 0, nValid = 0, nBad = 0;
  // access, common, length, function
  logic [31:0] rows [0:5] = '{32'h0720_0001, 32'h8820_CECE, 32'h0720_CECE,
    32'h4721_0000, 32'h5021_0007, 32'h4821_0002};
  pcc_framer pcc_framer_inst (.mclk(mclk), .rst_n(rst_n), .isAccessSide(isAccessSide), .protoDisc(8'h48),
    .txReq(txReq), .txCommon(txCommon), .txAddr(txAddr), .txFunc(txFunc), .txGrade(8'h01),
    .txVariant(24'h00_0003), .txRejCause(8'h05), .txIfId(40'h00_0000_0009), .rxBit(rxBit), .rxFrame(rxFrame),
    .txBit(txBit), .txFrame(txFrame), .txBusy(txBusy), .rxValid(rxValid), .rxError(rxError),
    .rxType(rxType), .rxAddr(rxAddr), .rxFunc(rxFunc));
  pcc_peer_model pcc_peer_model_inst (.mclk(mclk), .txBit(txBit), .txFrame(txFrame), .rxBit(rxBit),
    .rxFrame(rxFrame), .got(got), .gotLen(gotLen), .nMsg(nMsg));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    nValid <= nValid + rxValid;
    nBad <= nBad + rxError;
    if (cycles == 32'h0000_1388) begin
      nErrors = nErrors + 1;
      report_and_stop();
    end
  end
  task automatic check(input logic [15:0] act, input logic [15:0] exp);
    totalChecks = totalChecks + 1;
    if (act !== exp) begin
      nErrors = nErrors + 1;
      $display("unexpected at %0t: got %h want %h", $time, act, exp);
    end
  endtask
  task automatic waitMsg();
    logic [15:0] k;
    k = nMsg;
    for (int c = 0; c < 400 && nMsg == k; c++) @(negedge mclk);
    msgs = msgs + 16'h0001;
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ----
  // sequence
  // ----
  initial begin
    {rst_n, isAccessSide, txReq, txCommon, txAddr, txFunc, msgs} = '0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    check({12'h000, txBusy, txFrame, rxValid, rxError}, 16'h0000);
    repeat (3) @(posedge mclk);
    // request held two edges: the second is refused while busy
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      {isAccessSide, txCommon} <= rows[i][31:30];
      txFunc <= rows[i][23:0];
      txAddr <= {8'h5A, 5'h00, 3'(i)};
      txReq <= 1'b1;
      repeat (2) @(posedge mclk);
      txReq <= 1'b0;
      waitMsg();
      check(nMsg, msgs);
      check(gotLen, {10'h000, rows[i][29:24]});
      check({got[7:0], got[31:24]}, {8'h48, 6'h04, rows[i][30], 1'b0});
      check({got[15:8], got[23:16]}, txAddr);
      check({got[39:32], got[55:48]}, {7'h10, rows[i][30], rows[i][7:0]});
      if (rows[i][29:24] == 6'h08) check({12'h000, got[63:60]}, {15'h0007, rows[i][30]});
      if (rows[i][29:24] == 6'h10) check({got[87:80], got[63:56]}, 16'hF522);
      if (rows[i][29:24] == 6'h10) check({got[95:88], got[127:120]}, 16'h2309);
    end
    for (int j = 0; j < 2; j++) begin
      pcc_peer_model_inst.send({8'h30, 8'h12, 7'h10, j[0], 6'h04, j[0], 1'b0, 16'hC35A, 8'h48}, 7);
      waitMsg();
      check(nMsg, msgs);
      check({9'h000, rxType}, {12'h001, 2'h0, j[0], 1'b0});
      check(rxAddr, 16'h5AC3);
      check(rxFunc[15:0], 16'h1230);
      check({8'h00, rxFunc[23:16]}, {8'h00, 7'h10, j[0]});
      check({got[31:24], got[39:32]}, {6'h04, j[0], 1'b1, 7'h10, j[0]});
      check({got[15:8], got[23:16]}, 16'h5AC3);
      check({got[47:40], got[55:48]}, 16'h1230);
      check(gotLen, 16'h0007);
    end
    // common control carrying a rejection cause: eight octets
    pcc_peer_model_inst.send({8'hF5, 8'h02, 8'h12, 8'h21, 8'h12, 16'hC35A, 8'h48}, 8);
    waitMsg();
    check(nMsg, msgs);
    check({9'h000, rxType}, 16'h0012);
    check({got[31:24], got[55:48]}, 16'h1302);
    check(gotLen, 16'h0007);
    check(16'(nValid), 16'h0003);
    pcc_peer_model_inst.send({8'h30, 8'h12, 8'h20, 8'h10, 16'hC35A, 8'h49}, 7);
    repeat (300) @(negedge mclk);
    check(nMsg, msgs);
    check(16'(nBad), 16'h0001);
    report_and_stop();
  end
endmodule
`default_nettype wire
